//--- src/ivw_limits.sv
`timescale 1ns/1ps
// How it works
// - over-voltage threshold counts in 500 mV steps
// - over-voltage threshold resets to 0x20, 16 V
// - under-voltage threshold writable and readable at 58h
// - input below under-voltage threshold sets warning flag
// - under-voltage warning pulls the alert output low
// - under-voltage threshold counts in 250 mV steps
// - under-voltage threshold resets to 0x1C, 7.0 V
// - input above over-voltage threshold at 57h sets flag, alert
// - flags clear on clear command once condition gone
module ivw_limits #(
  parameter int DATA_W = ivw_pkg::DATA_W,
  parameter int CMD_W  = ivw_pkg::CMD_W
) (
  // system clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // measurement link, on its own clock
  input  wire logic              vinClk,
  input  wire logic              vinSampleValid,
  input  wire logic [DATA_W-1:0] vinSample,
  output logic                   vinSampleReady,
  // command port from the bus interface logic
  input  wire logic              cmdValid,
  input  wire logic              cmdWrite,
  input  wire logic [CMD_W-1:0]  cmdCode,
  input  wire logic [DATA_W-1:0] cmdWdata,
  output logic                   rspValid,
  output logic                   rspErr,
  output logic [DATA_W-1:0]      rspData,
  // warning flags toward the status registers
  output logic                   uvWarnFlag,
  output logic                   ovWarnFlag,
  // open-drain alert pin
  output logic                   alert_out_n,
  output logic                   alertOe
);
  import ivw_pkg::*;

  localparam int LAST = SYNC_STAGES - 1;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0]      ovLimit;
    logic [DATA_W-1:0]      uvLimit;
    logic [SYNC_STAGES-1:0] reqSync;
    logic                   reqLvl;
    logic                   ackTgl;
    logic [DATA_W-1:0]      vinMeas;
    logic                   measValid;
    logic                   uvFlag;
    logic                   ovFlag;
    logic                   alertAct;
    logic                   rspValid;
    logic                   rspErr;
    logic [DATA_W-1:0]      rspData;
  } ivw_state_s;

  ivw_state_s        st_r;
  ivw_state_s        st_nxt;
  logic              linkReqTgl;
  logic [DATA_W-1:0] linkWord;
  logic [LEVEL_W-1:0] ovLevel;
  logic [LEVEL_W-1:0] uvLevel;
  logic [LEVEL_W-1:0] measLevel;
  logic              uvCond;
  logic              ovCond;
  logic              clearCmd;
  logic              wrOv;
  logic              wrUv;
  logic              rdOv;
  logic              rdUv;

  // ------------------------------------------------------------------
  // link domain capture
  // ------------------------------------------------------------------
  ivw_vin_link #(
    .DATA_W (DATA_W)
  ) u_link (
    .vinClk         (vinClk),
    .rst            (rst),
    .vinSampleValid (vinSampleValid),
    .vinSample      (vinSample),
    .vinSampleReady (vinSampleReady),
    .linkReqTgl     (linkReqTgl),
    .linkWord       (linkWord),
    .sysAckTgl      (st_r.ackTgl)
  );

  // ------------------------------------------------------------------
  // threshold compare
  // ------------------------------------------------------------------
  // all levels brought to the measurement lsb before comparing
  assign ovLevel   = LEVEL_W'(st_r.ovLimit) * LEVEL_W'(OV_SCALE);
  assign uvLevel   = LEVEL_W'(st_r.uvLimit) * LEVEL_W'(UV_SCALE);
  assign measLevel = LEVEL_W'(st_r.vinMeas);
  // no decision before the first sample has arrived
  assign uvCond    = st_r.measValid && (measLevel < uvLevel);
  assign ovCond    = st_r.measValid && (measLevel > ovLevel);

  // ------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------
  assign wrOv     = cmdValid && cmdWrite && (cmdCode == CMD_VIN_OV_WARN);
  assign wrUv     = cmdValid && cmdWrite && (cmdCode == CMD_VIN_UV_WARN);
  assign rdOv     = cmdValid && !cmdWrite && (cmdCode == CMD_VIN_OV_WARN);
  assign rdUv     = cmdValid && !cmdWrite && (cmdCode == CMD_VIN_UV_WARN);
  assign clearCmd = cmdValid && cmdWrite && (cmdCode == CMD_CLEAR_FAULTS);

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.rspValid = cmdValid;
    st_nxt.rspErr   = 1'b0;
    st_nxt.rspData  = '0;

    // request toggle from the link counts once two stages agree
    st_nxt.reqSync = {st_r.reqSync[LAST-1:0], linkReqTgl};
    if ((st_r.reqSync[LAST] == st_r.reqSync[LAST-1]) &&
        (st_r.reqSync[LAST] != st_r.reqLvl))
    begin
      st_nxt.reqLvl    = st_r.reqSync[LAST];
      st_nxt.ackTgl    = st_r.reqSync[LAST];
      st_nxt.vinMeas   = linkWord;
      st_nxt.measValid = 1'b1;
    end

    // range advice to the host is not enforced; any 11-bit value is stored
    if (wrOv)
    begin
      st_nxt.ovLimit = cmdWdata & LIMIT_WR_MASK;
    end
    if (wrUv)
    begin
      st_nxt.uvLimit = cmdWdata & LIMIT_WR_MASK;
    end

    if (rdOv)
    begin
      st_nxt.rspData = st_r.ovLimit;
    end
    else if (rdUv)
    begin
      st_nxt.rspData = st_r.uvLimit;
    end
    else if (cmdValid && !wrOv && !wrUv && !clearCmd)
    begin
      st_nxt.rspErr = 1'b1;
    end

    // a live condition outranks the clear, so no event is lost
    if (uvCond)
    begin
      st_nxt.uvFlag = 1'b1;
    end
    else if (clearCmd)
    begin
      st_nxt.uvFlag = 1'b0;
    end
    if (ovCond)
    begin
      st_nxt.ovFlag = 1'b1;
    end
    else if (clearCmd)
    begin
      st_nxt.ovFlag = 1'b0;
    end

    st_nxt.alertAct = st_nxt.uvFlag || st_nxt.ovFlag;
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r         <= '0;
      st_r.ovLimit <= OV_RESET;
      st_r.uvLimit <= UV_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign rspValid    = st_r.rspValid;
  assign rspErr      = st_r.rspErr;
  assign rspData     = st_r.rspData;
  assign uvWarnFlag  = st_r.uvFlag;
  assign ovWarnFlag  = st_r.ovFlag;
  // pin is only ever pulled low, released otherwise
  assign alert_out_n = !st_r.alertAct;
  assign alertOe     = st_r.alertAct;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  logic               firstCyc_r;
  logic [LEVEL_W-1:0] ovRef;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      firstCyc_r <= 1'b1;
    end
    else
    begin
      firstCyc_r <= 1'b0;
    end
  end

  assign ovRef = {1'b0, st_r.ovLimit, 1'b0};

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence seqWriteUv;
    cmdValid && cmdWrite && (cmdCode == CMD_VIN_UV_WARN);
  endsequence

  sequence seqReadUv;
    cmdValid && !cmdWrite && (cmdCode == CMD_VIN_UV_WARN);
  endsequence

  sequence seqUvLow;
    st_r.measValid && (st_r.vinMeas < st_r.uvLimit);
  endsequence

  resetLimits_a: assert property (firstCyc_r |->
      (st_r.ovLimit == OV_RESET) && (st_r.uvLimit == UV_RESET))
    else $error("threshold reset values wrong");

  uvReadback_a: assert property (seqWriteUv ##1 !cmdValid ##1 seqReadUv |=>
      rspValid && (rspData == ($past(cmdWdata, 3) & LIMIT_WR_MASK)))
    else $error("under-voltage threshold readback mismatch");

  upperZero_a: assert property (rspValid |-> ((rspData & ~LIMIT_WR_MASK) == '0))
    else $error("read-only threshold bits read nonzero");

  uvAlert_a: assert property (seqUvLow |=> uvWarnFlag ##0 !alert_out_n ##0 alertOe)
    else $error("under-voltage did not flag and alert");

  uvScale_a: assert property (st_r.measValid &&
      (17'(st_r.vinMeas) + 17'h00001 == 17'(st_r.uvLimit)) |=> uvWarnFlag)
    else $error("under-voltage compare not on 250 mV lsb");

  ovScale_a: assert property (st_r.measValid &&
      (LEVEL_W'(st_r.vinMeas) == ovRef + LEVEL_W'(1)) |=> ovWarnFlag && !alert_out_n)
    else $error("over-voltage compare not on 500 mV lsb");

  ovAtLimit_a: assert property (st_r.measValid && !ovWarnFlag &&
      (LEVEL_W'(st_r.vinMeas) == ovRef) |=> !ovWarnFlag)
    else $error("over-voltage flagged at the threshold itself");

  flagHold_a: assert property ((uvWarnFlag || ovWarnFlag) && !clearCmd |=>
      (uvWarnFlag || ovWarnFlag) [*1] ##0 !alert_out_n)
    else $error("warning flag dropped without a clear");

  clearOnly_a: assert property ($fell(uvWarnFlag) |->
      $past(clearCmd) && !$past(uvCond))
    else $error("under-voltage flag cleared while condition present");

  rspTiming_a: assert property (cmdValid |=> rspValid ##1 (rspValid == $past(cmdValid)))
    else $error("command answer not one cycle later");

endmodule

//--- shared/ivw_pkg.sv
package ivw_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int DATA_W      = 16;
  localparam int CMD_W       = 8;
  localparam int SYNC_STAGES = 3;

  // ------------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------------
  localparam logic [CMD_W-1:0] CMD_VIN_OV_WARN  = 8'h57;
  localparam logic [CMD_W-1:0] CMD_VIN_UV_WARN  = 8'h58;
  localparam logic [CMD_W-1:0] CMD_CLEAR_FAULTS = 8'h03;

  // ------------------------------------------------------------------
  // threshold layout and reset values
  // ------------------------------------------------------------------
  localparam logic [DATA_W-1:0] OV_RESET      = 16'h0020;
  localparam logic [DATA_W-1:0] UV_RESET      = 16'h001c;
  localparam logic [DATA_W-1:0] LIMIT_WR_MASK = 16'h07ff;

  // ------------------------------------------------------------------
  // scaling, in millivolts per lsb
  // ------------------------------------------------------------------
  localparam int OV_LSB_MV   = 500;
  localparam int UV_LSB_MV   = 250;
  localparam int MEAS_LSB_MV = 250;
  localparam int OV_SCALE    = OV_LSB_MV / MEAS_LSB_MV;
  localparam int UV_SCALE    = UV_LSB_MV / MEAS_LSB_MV;
  localparam int LEVEL_W     = DATA_W + 2;

endpackage

//--- src/ivw_vin_link.sv
`timescale 1ns/1ps
module ivw_vin_link #(
  parameter int DATA_W = ivw_pkg::DATA_W
) (
  // link clock and reset
  input  wire logic              vinClk,
  input  wire logic              rst,
  // measurement samples from the converter front end
  input  wire logic              vinSampleValid,
  input  wire logic [DATA_W-1:0] vinSample,
  output logic                   vinSampleReady,
  // crossing toward the system domain
  output logic                   linkReqTgl,
  output logic [DATA_W-1:0]      linkWord,
  input  wire logic              sysAckTgl
);
  import ivw_pkg::*;

  localparam int LAST = SYNC_STAGES - 1;

  typedef struct packed {
    logic                   reqTgl;
    logic [SYNC_STAGES-1:0] ackSync;
    logic                   ackLvl;
    logic [DATA_W-1:0]      word;
  } ivw_link_s;

  ivw_link_s st_r;
  ivw_link_s st_nxt;
  logic      busy;

  // word stays frozen until the system side has echoed the toggle
  assign busy           = st_r.reqTgl != st_r.ackLvl;
  assign vinSampleReady = !busy;
  assign linkReqTgl     = st_r.reqTgl;
  assign linkWord       = st_r.word;

  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.ackSync = {st_r.ackSync[LAST-1:0], sysAckTgl};
    if (st_r.ackSync[LAST] == st_r.ackSync[LAST-1])
    begin
      st_nxt.ackLvl = st_r.ackSync[LAST];
    end
    // samples offered while busy are refused through the ready output
    if (vinSampleValid && !busy)
    begin
      st_nxt.word   = vinSample;
      st_nxt.reqTgl = !st_r.reqTgl;
    end
  end

  always_ff @(posedge vinClk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  wordHeld_a: assert property (@(posedge vinClk) disable iff (rst)
    busy |=> (busy || $past(busy)) && (linkWord == $past(linkWord) || !$past(busy)))
    else $error("link word changed while the system side still reads it");

endmodule

//--- tb/ivw_vin_src.sv
`timescale 1ns/1ps
module ivw_vin_src (
  // link clock made here, still between samples
  output logic                      vinClk,
  // sample offer toward the block
  output logic                      vinSampleValid,
  output logic [ivw_pkg::DATA_W-1:0] vinSample,
  input  wire logic                 vinSampleReady
);
  import ivw_pkg::*;

  initial
  begin
    vinClk = 1'b0;
    vinSampleValid = 1'b0;
    vinSample = 16'h0000;
  end

  task automatic tick(input int n);
    repeat (n)
    begin
      #16 vinClk = 1'b1;
      #16 vinClk = 1'b0;
    end
  endtask

  // holds the offer until ready is seen at a rising edge
  task automatic send(input logic [DATA_W-1:0] v);
    logic tk;
    tk = 1'b0;
    #3 vinSample = v;
    vinSampleValid = 1'b1;
    while (!tk)
    begin
      #16 tk = vinSampleReady;
      vinClk = 1'b1;
      #3 if (tk)
      begin
        vinSampleValid = 1'b0;
        // released bus does not keep the last value
        vinSample = ~v;
      end
      #13 vinClk = 1'b0;
    end
    // keep clocking so the acknowledge can come back
    tick(16);
  endtask
endmodule

//--- tb/input_voltage_warning_limits_tb.sv
`timescale 1ns/1ps
module input_voltage_warning_limits_tb;
  import ivw_pkg::*;

  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic              cmdValid = 1'b0;
  logic              cmdWrite = 1'b0;
  logic [CMD_W-1:0]  cmdCode = 8'h00;
  logic [DATA_W-1:0] cmdWdata = 16'h0000;
  logic              vinClk;
  logic              vinSampleValid;
  logic              vinSampleReady;
  logic [DATA_W-1:0] vinSample;
  logic              rspValid;
  logic              rspErr;
  logic [DATA_W-1:0] rspData;
  logic              uvWarnFlag;
  logic              ovWarnFlag;
  logic              alert_out_n;
  logic              alertOe;
  logic [DATA_W-1:0] rd;
  logic              er;
  int                failures = 0;
  int                samples_checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  ivw_limits dut (
    .clk_sys(clk_sys), .rst(rst), .vinClk(vinClk),
    .vinSampleValid(vinSampleValid), .vinSample(vinSample),
    .vinSampleReady(vinSampleReady), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdCode(cmdCode), .cmdWdata(cmdWdata), .rspValid(rspValid), .rspErr(rspErr),
    .rspData(rspData), .uvWarnFlag(uvWarnFlag), .ovWarnFlag(ovWarnFlag),
    .alert_out_n(alert_out_n), .alertOe(alertOe)
  );

  ivw_vin_src src (
    .vinClk(vinClk), .vinSampleValid(vinSampleValid),
    .vinSample(vinSample), .vinSampleReady(vinSampleReady)
  );

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // answer is looked at in the one cycle it stands
  task automatic cmd(input logic w, input logic [CMD_W-1:0] c, input logic [DATA_W-1:0] d);
    @(negedge clk_sys);
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdCode = c;
    cmdWdata = d;
    @(negedge clk_sys);
    cmdValid = 1'b0;
    rd = rspData;
    er = rspErr;
    check({15'h0000, rspValid}, 16'h0001);
  endtask

  task automatic rdchk(input logic [CMD_W-1:0] c, input logic [DATA_W-1:0] exp);
    cmd(1'b0, c, 16'h0000);
    check(rd, exp);
  endtask

  task automatic flags(input logic uv, input logic ov);
    @(negedge clk_sys);
    check({12'h000, uvWarnFlag, ovWarnFlag, alert_out_n, alertOe},
          {12'h000, uv, ov, ~(uv | ov), uv | ov});
  endtask

  task automatic meas(input logic [DATA_W-1:0] v, input logic uv, input logic ov);
    src.send(v);
    check({15'h0000, vinSampleReady}, 16'h0001);
    flags(uv, ov);
  endtask

  task automatic complete_run;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    failures++;
    complete_run;
  end

  initial
  begin
    fork
      src.tick(4);
      repeat (6) @(negedge clk_sys);
    join
    rst = 1'b0;
    flags(1'b0, 1'b0);
    rdchk(8'h57, 16'h0020);
    rdchk(8'h58, 16'h001c);
    cmd(1'b1, 8'h58, 16'hffff);
    rdchk(8'h58, 16'h07ff);
    cmd(1'b1, 8'h57, 16'hf801);
    rdchk(8'h57, 16'h0001);
    // unknown code is refused and stores nothing
    cmd(1'b1, 8'h99, 16'h0005);
    check({15'h0000, er}, 16'h0001);
    check(rd, 16'h0000);
    rdchk(8'h58, 16'h07ff);
    cmd(1'b1, 8'h57, 16'h0020);
    cmd(1'b1, 8'h58, 16'h001d);
    // 7.25 V against a 7.25 V limit: equal is not below
    meas(16'h001d, 1'b0, 1'b0);
    meas(16'h001c, 1'b1, 1'b0);
    cmd(1'b1, 8'h03, 16'h0000);
    flags(1'b1, 1'b0);
    meas(16'h0030, 1'b1, 1'b0);
    cmd(1'b1, 8'h03, 16'h0000);
    flags(1'b0, 1'b0);
    // 16 V on the 250 mV scale is 0x40
    meas(16'h0040, 1'b0, 1'b0);
    meas(16'h0041, 1'b0, 1'b1);
    meas(16'h0030, 1'b0, 1'b1);
    cmd(1'b1, 8'h03, 16'h0000);
    flags(1'b0, 1'b0);
    // lowering the limit re-judges the held 12 V sample
    cmd(1'b1, 8'h57, 16'h0010);
    flags(1'b0, 1'b1);
    // second reset in mid-run
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    check({15'h0000, vinSampleReady}, 16'h0001);
    flags(1'b0, 1'b0);
    rdchk(8'h57, 16'h0020);
    rdchk(8'h58, 16'h001c);
    complete_run;
  end
endmodule
